//--- verilog/css_pkg.sv
// Package with constants and types for the configuration save/restore block
`default_nettype none
package css_pkg;
    // Number of user slots
    localparam int USER_SLOTS = 16;
    // Slot code width: 0 is factory, 1..16 are user slots
    localparam int SLOT_W = 5;
    // Factory slot code
    localparam logic [4:0] SLOT_FACTORY = 5'h00;
    // Top user slot code
    localparam logic [4:0] SLOT_LAST_USER = 5'h10;
    // Default slot selector after reset
    localparam logic [4:0] SEL_RST = 5'h00;
    // Factory boot choice value in a blank store
    localparam logic [4:0] BOOT_RST = 5'h00;
    // Register index width
    localparam int ADDR_W = 8;
    // Control register offsets
    localparam logic [7:0] OFS_SELECT = 8'h00;
    localparam logic [7:0] OFS_COMMAND = 8'h04;
    localparam logic [7:0] OFS_BOOT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    // Live settings window base and word count
    localparam logic [7:0] OFS_LIVE_BASE = 8'h40;
    localparam int LIVE_WORDS = 8;
    // Command register bit positions
    localparam int CMD_STORE_BIT = 0;
    localparam int CMD_RESTORE_BIT = 1;
    // Status bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_MATCH_BIT = 1;
    localparam int ST_REFUSED_BIT = 2;
    // Controller states
    typedef enum logic [2:0] {
        CSS_BOOT = 3'b000,
        CSS_BOOT_LOAD = 3'b001,
        CSS_IDLE = 3'b010,
        CSS_STORE = 3'b011,
        CSS_RESTORE = 3'b100
    } css_state_e;
endpackage
`default_nettype wire

//--- verilog/css_nv_if.sv
// Interface between the controller and the non-volatile slot store
`default_nettype none
interface css_nv_if #(
    parameter int SLOT_W = 5,
    parameter int IDX_W = 3,
    parameter int DATA_W = 32
);
    logic wr_en;
    logic [SLOT_W-1:0] slot;
    logic [IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic boot_wr;
    logic [SLOT_W-1:0] boot_wdata;
    logic [SLOT_W-1:0] boot_rdata;
    // Controller side
    modport ctrl (output wr_en, slot, idx, wdata, boot_wr, boot_wdata,
                  input rdata, boot_rdata);
    // Store side
    modport store (input wr_en, slot, idx, wdata, boot_wr, boot_wdata,
                   output rdata, boot_rdata);
endinterface
`default_nettype wire

//--- verilog/css_nv_store.sv
// Non-volatile slot memory model: factory, user slots and boot choice
`default_nettype none
module css_nv_store #(
    parameter int WORDS = 8,
    parameter int DATA_W = 32,
    parameter logic [DATA_W-1:0] FACTORY_WORD = 32'h0000_0000
) (
    // Clock
    input wire logic clk_i,
    // Port to the controller
    css_nv_if.store nv
);
    // Slot 0 is factory, 1..16 user; no reset, contents persist
    logic [DATA_W-1:0] mem [0:css_pkg::USER_SLOTS][0:WORDS-1];
    // Stored boot choice
    logic [css_pkg::SLOT_W-1:0] boot_r;

    // Shipped state: every slot equals factory, boot picks factory
    initial begin
        for (int s = 0; s <= css_pkg::USER_SLOTS; s++) begin
            for (int w = 0; w < WORDS; w++) begin
                mem[s][w] = FACTORY_WORD + DATA_W'(w);
            end
        end
        boot_r = css_pkg::BOOT_RST;
    end

    // Writes only land in user slots; factory is read only
    // Plain clocked process, as the contents are also preset at start
    always @(posedge clk_i) begin
        if (nv.wr_en && nv.slot != css_pkg::SLOT_FACTORY
            && nv.slot <= css_pkg::SLOT_LAST_USER) begin
            mem[nv.slot][nv.idx] <= nv.wdata;
        end
    end

    // Boot choice kept across resets, preset at start as well
    always @(posedge clk_i) begin
        if (nv.boot_wr) begin
            boot_r <= nv.boot_wdata;
        end
    end

    // Asynchronous read of selected word
    assign nv.rdata = mem[nv.slot][nv.idx];
    assign nv.boot_rdata = boot_r;
endmodule
`default_nettype wire

//--- verilog/css_config_set.sv
// Configuration save/restore controller with live settings and registers
//
// The register addresses and the strobed register port are this design's own decisions.
`default_nettype none
// How it works
// - Sixteen user slots plus read-only factory slot
// - Store copies all live words to slot
// - After store, live equals chosen slot
// - Restore overwrites live from selected slot
// - Factory restore accepted whenever idle
// - Reset loads boot-choice slot into live
// - Live settings volatile, lost on reset
// - Host writes change live settings immediately while idle; during a copy they are dropped
// - Shipped user slots equal factory slot
// - First power-up loads factory slot
module css_config_set #(
    parameter int WORDS = css_pkg::LIVE_WORDS,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [css_pkg::ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // Live settings to the rest of the device
    output logic [WORDS*DATA_W-1:0] live_o,
    // Controller state
    output logic busy_o,
    output logic live_valid_o
);
    // Copies move one word per cycle and commands are refused unless idle.
    // Live writes during a copy are dropped so the copy stays coherent.
    // The slot store is never reset, so a store survives rst_n_i.
    // Word index width and the last word of a copy
    localparam int IDX_W = $clog2(WORDS);
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(WORDS - 1);
    // Lowest slot code that takes a store
    localparam logic [css_pkg::SLOT_W-1:0] SLOT_USER1 = 5'h01;

    // Link to the slot store
    css_nv_if #(.SLOT_W(css_pkg::SLOT_W), .IDX_W(IDX_W),
                .DATA_W(DATA_W)) nv ();

    // Slot store instance
    css_nv_store #(.WORDS(WORDS), .DATA_W(DATA_W)) u_store (
        .clk_i(clk_i),
        .nv(nv.store)
    );

    // Live settings, volatile
    logic [DATA_W-1:0] live_r [0:WORDS-1];
    // Slot selector
    logic [css_pkg::SLOT_W-1:0] sel_r;
    // Slot being transferred
    logic [css_pkg::SLOT_W-1:0] op_slot_r;
    // Word counter for copies
    logic [IDX_W-1:0] idx_r;
    // Controller state
    css_pkg::css_state_e state_r;
    // Live matches a stored slot
    logic match_r;
    // Slot that live matches
    logic [css_pkg::SLOT_W-1:0] match_slot_r;
    // Last command refused
    logic refused_r;
    // Boot choice write pulse and value
    logic boot_wr_r;
    logic [css_pkg::SLOT_W-1:0] boot_wdata_r;
    // Read data register
    logic [DATA_W-1:0] rdata_r;
    // Live valid flag
    logic valid_r;

    // Write to the slot selector
    logic wr_sel;
    // Write to the command register
    logic wr_cmd;
    // Write to the boot choice
    logic wr_boot;
    // Write inside the live settings window
    logic wr_live;
    // Live word addressed by the bus
    logic [IDX_W-1:0] live_idx;
    // Store and restore bits of a command write
    logic cmd_store;
    logic cmd_restore;
    // Selector names a slot that can be read
    logic slot_ok;
    // Selector names a slot that can be written
    logic store_ok;
    // Command accepted this cycle, a copy starts
    logic start_ok;
    // Copy ends at this edge
    logic copy_last;
    // Next value of the busy output
    logic busy_nxt;

    // Address decode; the window is word aligned, low bits ignored
    always_comb begin
        // Register strobes
        wr_sel = wr_i && addr_i == css_pkg::OFS_SELECT;
        wr_cmd = wr_i && addr_i == css_pkg::OFS_COMMAND;
        wr_boot = wr_i && addr_i == css_pkg::OFS_BOOT;
        wr_live = wr_i && addr_i >= css_pkg::OFS_LIVE_BASE
            && addr_i < css_pkg::OFS_LIVE_BASE + 8'(WORDS * 4);
        live_idx = IDX_W'((addr_i - css_pkg::OFS_LIVE_BASE) >> 2);
        // Command bits, acted on only when idle
        cmd_store = wr_cmd && wdata_i[css_pkg::CMD_STORE_BIT];
        cmd_restore = wr_cmd && wdata_i[css_pkg::CMD_RESTORE_BIT];
        // Factory or user 1..16 is a valid restore source
        slot_ok = sel_r <= css_pkg::SLOT_LAST_USER;
        // Only user slots take a store; factory stays read only
        store_ok = sel_r >= SLOT_USER1
            && sel_r <= css_pkg::SLOT_LAST_USER;
        // Restore wins when both bits are set
        start_ok = state_r == css_pkg::CSS_IDLE
            && ((cmd_restore && slot_ok) || (cmd_store && store_ok));
    end

    // Busy follows the controller: high exactly while not idle
    always_comb begin
        // Last word of a boot copy, store or restore
        copy_last = state_r != css_pkg::CSS_IDLE
            && state_r != css_pkg::CSS_BOOT && idx_r == IDX_LAST;
        // A refused command never raises busy
        busy_nxt = start_ok
            || (state_r != css_pkg::CSS_IDLE && !copy_last);
    end

    // Store port drive
    // The slot follows op_slot_r, latched when a copy starts
    always_comb begin
        // Write enable only while storing
        nv.wr_en = state_r == css_pkg::CSS_STORE;
        nv.slot = op_slot_r;
        nv.idx = idx_r;
        nv.wdata = live_r[idx_r];
        nv.boot_wr = boot_wr_r;
        nv.boot_wdata = boot_wdata_r;
    end

    // Sequencer: boot load, store and restore copies
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Start from the boot fetch; live is reloaded
            state_r <= css_pkg::CSS_BOOT;
            op_slot_r <= css_pkg::SLOT_FACTORY;
            idx_r <= '0;
        end else begin
            case (state_r)
                // Fetch boot choice after reset
                css_pkg::CSS_BOOT: begin
                    // The boot choice survives reset in the store
                    op_slot_r <= nv.boot_rdata;
                    idx_r <= '0;
                    state_r <= css_pkg::CSS_BOOT_LOAD;
                end
                // Copy boot slot into live
                css_pkg::CSS_BOOT_LOAD: begin
                    // Word idx_r is read from the boot slot this cycle
                    if (idx_r == IDX_LAST) begin
                        state_r <= css_pkg::CSS_IDLE;
                    end
                    idx_r <= idx_r + 1'b1;
                end
                // Accept commands; restore of factory is never gated
                css_pkg::CSS_IDLE: begin
                    idx_r <= '0;
                    // Latch the selector so a later write cannot move a copy
                    op_slot_r <= sel_r;
                    // Restore is checked first so it wins over store
                    if (cmd_restore && slot_ok) begin
                        state_r <= css_pkg::CSS_RESTORE;
                    end else if (cmd_store && store_ok) begin
                        state_r <= css_pkg::CSS_STORE;
                    end
                end
                // Copy words one per cycle, live to slot or slot to live
                // One word per cycle, the counter wraps to zero at the end
                css_pkg::CSS_STORE,
                css_pkg::CSS_RESTORE: begin
                    if (idx_r == IDX_LAST) begin
                        state_r <= css_pkg::CSS_IDLE;
                    end
                    idx_r <= idx_r + 1'b1;
                end
                default: begin
                    // Unused codes fall back to idle
                    state_r <= css_pkg::CSS_IDLE;
                end
            endcase
        end
    end

    // Live settings: cleared at reset, loaded by copies or host writes
    // Copies take priority; host writes only land while idle
    generate
        for (genvar g = 0; g < WORDS; g++) begin : g_live
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    // Unsaved changes are lost here
                    live_r[g] <= '0;
                end else if ((state_r == css_pkg::CSS_BOOT_LOAD
                    || state_r == css_pkg::CSS_RESTORE)
                    && idx_r == IDX_W'(g)) begin
                    live_r[g] <= nv.rdata;
                end else if (wr_live && state_r == css_pkg::CSS_IDLE
                    && live_idx == IDX_W'(g)) begin
                    // Host write lands at once; no slot is touched
                    live_r[g] <= wdata_i;
                end
            end
            // Flatten onto the live bus
            assign live_o[g*DATA_W +: DATA_W] = live_r[g];
        end
    endgenerate

    // Slot selector register
    // Reset returns to the factory slot
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_r <= css_pkg::SEL_RST;
        end else if (wr_sel) begin
            // Any code is kept; range is checked per command
            sel_r <= wdata_i[css_pkg::SLOT_W-1:0];
        end
    end

    // Boot choice update goes straight to the slot store
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            boot_wr_r <= 1'b0;
            boot_wdata_r <= css_pkg::BOOT_RST;
        end else begin
            // Out-of-range choices are not written
            boot_wr_r <= wr_boot
                && wdata_i[css_pkg::SLOT_W-1:0] <= css_pkg::SLOT_LAST_USER;
            boot_wdata_r <= wdata_i[css_pkg::SLOT_W-1:0];
        end
    end

    // Tracks whether live equals a stored slot
    // Boot copy, store and restore all set it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            match_r <= 1'b0;
            match_slot_r <= css_pkg::SLOT_FACTORY;
        end else if (state_r != css_pkg::CSS_IDLE
            && state_r != css_pkg::CSS_BOOT && idx_r == IDX_LAST) begin
            // A finished copy makes live equal the slot
            match_r <= 1'b1;
            match_slot_r <= op_slot_r;
        end else if (wr_live && state_r == css_pkg::CSS_IDLE) begin
            // Any host edit breaks the match
            match_r <= 1'b0;
        end
    end

    // Refused command flag; a new command write updates it
    // Stays set until the next command write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            refused_r <= 1'b0;
        end else if (wr_cmd) begin
            // Busy, bad slot or store to factory
            refused_r <= (state_r != css_pkg::CSS_IDLE)
                || (cmd_restore && !slot_ok)
                || (!cmd_restore && cmd_store && !store_ok);
        end
    end

    // Live valid once the boot copy finished
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_r <= 1'b0;
        end else if (state_r == css_pkg::CSS_BOOT_LOAD
            && idx_r == IDX_LAST) begin
            // Stays high until the next reset
            valid_r <= 1'b1;
        end
    end

    // Busy output register, a registered copy of busy_nxt
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Boot copy follows reset, so busy starts high
            busy_o <= 1'b1;
        end else begin
            busy_o <= busy_nxt;
        end
    end

    // Read data, valid the cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= '0;
        end else if (rd_i) begin
            // Unmapped addresses read as zero
            rdata_r <= '0;
            case (addr_i)
                // Slot selector
                css_pkg::OFS_SELECT: begin
                    rdata_r <= DATA_W'(sel_r);
                end
                // Boot choice as held in the slot store
                css_pkg::OFS_BOOT: begin
                    rdata_r <= DATA_W'(nv.boot_rdata);
                end
                // Status: busy, match, refused and matched slot
                css_pkg::OFS_STATUS: begin
                    rdata_r[css_pkg::ST_BUSY_BIT] <=
                        state_r != css_pkg::CSS_IDLE;
                    rdata_r[css_pkg::ST_MATCH_BIT] <= match_r;
                    rdata_r[css_pkg::ST_REFUSED_BIT] <= refused_r;
                    rdata_r[12:8] <= match_slot_r;
                end
                // Live settings window, zero outside it
                default: begin
                    if (addr_i >= css_pkg::OFS_LIVE_BASE
                        && addr_i < css_pkg::OFS_LIVE_BASE
                        + 8'(WORDS * 4)) begin
                        rdata_r <= live_r[live_idx];
                    end
                end
            endcase
        end else begin
            // No strobe: the bus reads zero
            rdata_r <= '0;
        end
    end

    // Outputs from flip-flops
    assign rdata_o = rdata_r;
    assign live_valid_o = valid_r;
endmodule
`default_nettype wire

//--- bench/css_config_set_monitor.sv
// Port checker for the configuration save/restore block
`default_nettype none
module css_config_set_monitor #(
    parameter int WORDS = 8,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [css_pkg::ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    // Live settings and state
    input wire logic [WORDS*DATA_W-1:0] live_o,
    input wire logic busy_o,
    input wire logic live_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Longest busy spell a boot copy or command may take
    localparam int BUSY_MAX = 2 * WORDS + 8;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_rdata_quiet: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data not zero outside a read");
    chk_valid_stays: assert property (live_valid_o |=> live_valid_o)
        else $error("live valid dropped");
    chk_busy_boot: assert property (!live_valid_o |-> busy_o)
        else $error("idle before boot load finished");
    chk_busy_bound: assert property (busy_o |-> ##[0:BUSY_MAX] !busy_o)
        else $error("busy spell too long");
    chk_live_write: assert property (wr_i && !busy_o &&
        addr_i == css_pkg::OFS_LIVE_BASE |=> live_o[DATA_W-1:0] == $past(wdata_i))
        else $error("live word write not applied");
    chk_live_hold: assert property (!busy_o && !wr_i |=> $stable(live_o))
        else $error("live settings changed without cause");
    chk_live_read: assert property (rd_i &&
        addr_i == css_pkg::OFS_LIVE_BASE + 8'h04 |=>
        rdata_o == $past(live_o[2*DATA_W-1:DATA_W]))
        else $error("live word readback wrong");
    chk_status_busy: assert property (rd_i &&
        addr_i == css_pkg::OFS_STATUS |=> rdata_o[0] == $past(busy_o))
        else $error("status busy bit wrong");
endmodule
bind css_config_set css_config_set_monitor #(
    .WORDS(WORDS),
    .DATA_W(DATA_W)
) i_mon (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .live_o(live_o),
    .busy_o(busy_o),
    .live_valid_o(live_valid_o)
);
`default_nettype wire

//--- bench/css_config_set_tb.sv
// Self-checking bench for the configuration save/restore block
`default_nettype none
module css_config_set_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus and observed signals
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic [8*32-1:0] live_o;
    logic busy_o;
    logic live_valid_o;
    logic [31:0] v;
    int fail_count = 0;
    int samples_checked = 0;
    // Ordinary rows: address, data written, value read back
    logic [7:0] row_a [4] = '{8'h40, 8'h5c, 8'h20, 8'h08};
    logic [31:0] row_d [4] = '{32'haa, 32'hbb, 32'hcc, 32'h11};
    logic [31:0] row_e [4] = '{32'haa, 32'hbb, 32'h0, 32'h0};
    css_config_set i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .live_o(live_o), .busy_o(busy_o), .live_valid_o(live_valid_o)
    );
    // Clock at 50 MHz
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Compare and report
    task automatic check(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // One-cycle register read, data taken the cycle after
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // Wait for busy low under a bound
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        while (busy_o !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            #1 n++;
        end
        check("busy", {31'h0, busy_o}, 32'h0);
    endtask
    // Select a slot and issue a command
    task automatic cmd(input logic [4:0] s, input logic [31:0] c);
        wr(css_pkg::OFS_SELECT, {27'h0, s});
        wr(css_pkg::OFS_COMMAND, c);
        wait_idle();
    endtask
    // Every live word against base plus index
    task automatic chk_live(input logic [31:0] b);
        for (int g = 0; g < 8; g++) begin
            check("live", live_o[g*32+:32], b + g);
        end
    endtask
    // Reset held 16 cycles, then boot load
    task automatic do_reset();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wait_idle();
        check("valid", {31'h0, live_valid_o}, 32'h1);
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        do_reset();
        chk_live(32'h0);
        for (int r = 0; r < 4; r++) begin
            wr(row_a[r], row_d[r]);
            rd(row_a[r], v);
            check("row", v, row_e[r]);
        end
        $display("rows done");
        for (int g = 0; g < 8; g++) wr(8'h40 + 8'(4 * g), 32'h100 + g);
        cmd(5'h03, 32'h1);
        rd(css_pkg::OFS_STATUS, v);
        check("status", v, 32'h0302);
        wr(8'h40, 32'hdead);
        rd(css_pkg::OFS_STATUS, v);
        check("match", {31'h0, v[1]}, 32'h0);
        cmd(5'h03, 32'h2);
        chk_live(32'h100);
        cmd(5'h00, 32'h2);
        chk_live(32'h0);
        cmd(5'h10, 32'h2);
        chk_live(32'h0);
        $display("store restore done");
        cmd(5'h00, 32'h1);
        rd(css_pkg::OFS_STATUS, v);
        check("refused", {31'h0, v[2]}, 32'h1);
        cmd(5'h11, 32'h2);
        rd(css_pkg::OFS_STATUS, v);
        check("refused", {31'h0, v[2]}, 32'h1);
        chk_live(32'h0);
        cmd(5'h03, 32'h3);
        chk_live(32'h100);
        rd(css_pkg::OFS_STATUS, v);
        check("status", v, 32'h0302);
        $display("refusals done");
        wr(css_pkg::OFS_BOOT, 32'h3);
        rd(css_pkg::OFS_BOOT, v);
        check("boot", v, 32'h3);
        wr(8'h44, 32'h55);
        do_reset();
        chk_live(32'h100);
        rd(css_pkg::OFS_BOOT, v);
        check("boot", v, 32'h3);
        $display("boot choice done");
        stop_test();
    end
endmodule
`default_nettype wire
